// [rtc_crystal_model.sv]
// watch crystal stand-in: delivers the synchronised crystal edge pulse.
// assumes the core takes one-cycle pulses on clk_i; the rate is sped up.
`timescale 1ns/1ps
`default_nettype none
module rtc_crystal_model (
    input wire logic clk_i,
    output logic tick_o
);
    logic phase_q = 1'b0;
    always_ff @(posedge clk_i)
    begin
        phase_q <= ~phase_q;
    end
    // one pulse every second system clock
    assign tick_o = phase_q;
endmodule : rtc_crystal_model
`default_nettype wire

// [rtc_interval.sv]
// interval alarm timer: counts the selected time base against a target.
// assumes tick inputs are one-cycle enable pulses.
`timescale 1ns/1ps
`default_nettype none
module rtc_interval (
    input wire logic clk_i,
    input wire logic por_i,
    input wire logic enable_i,
    input wire logic single_i,
    input wire logic [1:0] tick_sel_i,
    input wire logic [7:0] target_i,
    input wire logic tick_128_i,
    input wire logic tick_sec_i,
    input wire logic tick_min_i,
    input wire logic tick_hour_i,
    output logic elapsed_o
);
    logic [7:0] count_q;
    logic done_q;
    logic base_tick;
    logic hit;

    // time base mux
    assign base_tick = (tick_sel_i == rtc_pkg::TICK_128TH) ? tick_128_i :
                       (tick_sel_i == rtc_pkg::TICK_SECOND) ? tick_sec_i :
                       (tick_sel_i == rtc_pkg::TICK_MINUTE) ? tick_min_i : tick_hour_i;
    assign hit = base_tick && (count_q + 8'h01 == target_i);

    // interval count, restart or stop after a hit
    always_ff @(posedge clk_i)
    begin
        elapsed_o <= 1'b0;
        if (por_i || !enable_i)
        begin
            count_q <= 8'h00;
            done_q <= 1'b0;
        end
        else if (base_tick && !done_q)
        begin
            if (hit)
            begin
                count_q <= 8'h00;
                done_q <= single_i;
                elapsed_o <= 1'b1;
            end
            else
            begin
                count_q <= count_q + 8'h01;
            end
        end
    end
endmodule : rtc_interval
`default_nettype wire

// [rtc_pkg.sv]
// package for the real-time clock core: register offsets, field positions,
// reset values, key value and timebase counts.
// assumes an 8-bit special-function register bus with 8-bit addresses.
package rtc_pkg;
    // register offsets on the special-function register bus
    localparam logic [7:0] ADDR_CONFIG = 8'hA1;
    localparam logic [7:0] ADDR_HUNDREDTHS = 8'hA2;
    localparam logic [7:0] ADDR_SECONDS = 8'hA3;
    localparam logic [7:0] ADDR_MINUTES = 8'hA4;
    localparam logic [7:0] ADDR_HOURS = 8'hA5;
    localparam logic [7:0] ADDR_INTERVAL = 8'hA6;
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hC1;
    localparam logic [7:0] ADDR_NOMINAL_COMP = 8'hF6;
    localparam logic [7:0] ADDR_TEMP_COMP = 8'hF7;
    localparam logic [7:0] ADDR_INT_PIN_CFG = 8'hFF;

    // configuration register fields
    localparam int CFG_MIDNIGHT_BIT = 7;
    localparam int CFG_HOUR_WRAP_BIT = 6;
    localparam int CFG_TICK_SEL_HI = 5;
    localparam int CFG_TICK_SEL_LO = 4;
    localparam int CFG_SINGLE_BIT = 3;
    localparam int CFG_ALARM_BIT = 2;
    localparam int CFG_ENABLE_BIT = 1;
    localparam int CFG_RESERVED_BIT = 0;

    // reset values and key
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] TIMEKEEP_KEY = 8'hEA;

    // tick selection codes
    localparam logic [1:0] TICK_128TH = 2'h0;
    localparam logic [1:0] TICK_SECOND = 2'h1;
    localparam logic [1:0] TICK_MINUTE = 2'h2;
    localparam logic [1:0] TICK_HOUR = 2'h3;

    // counter wrap limits
    localparam logic [7:0] HUNDREDTHS_LAST = 8'h63;
    localparam logic [7:0] SIXTY_LAST = 8'h3B;
    localparam logic [7:0] HOURS_LAST_24 = 8'h17;
    localparam logic [7:0] HOURS_LAST_256 = 8'hFF;

    // crystal timebase
    localparam int CRYSTAL_HZ = 32768;
    localparam int HUNDREDTHS_PER_S = 100;
    localparam int EIGHTS_PER_S = 128;
    // crystal cycles per 1/128 s
    localparam int CYC_PER_128TH = CRYSTAL_HZ / EIGHTS_PER_S;
endpackage : rtc_pkg

// [rtc_tick_gen.sv]
// crystal-edge timebase: produces a 100 Hz and a 128 Hz enable pulse.
// assumes xtal_tick_i is a one-cycle pulse per 32.768 kHz crystal period.
`timescale 1ns/1ps
`default_nettype none
module rtc_tick_gen #(
    parameter int CRYSTAL_HZ = rtc_pkg::CRYSTAL_HZ
) (
    input wire logic clk_i,
    input wire logic por_i,
    input wire logic xtal_tick_i,
    input wire logic [7:0] nominal_comp_i,
    input wire logic [7:0] temp_comp_i,
    output logic tick_100_o,
    output logic tick_128_o
);
    // refuse crystal rates the 1/128 s divider or the 17-bit accumulators cannot serve
    if (CRYSTAL_HZ < 1024 || CRYSTAL_HZ > 65536)
    begin : g_rate_check
        $error("rtc_tick_gen: crystal rate out of range");
    end

    // signed trim in crystal cycles per second, applied once per second
    logic signed [9:0] trim;
    logic [16:0] acc_q;
    logic [16:0] acc_d;
    logic [16:0] limit;
    logic [6:0] eighth_q;
    logic [16:0] hacc_q;
    logic [16:0] hacc_d;
    logic hwrap;

    assign trim = 10'($signed(nominal_comp_i)) + 10'($signed(temp_comp_i));
    assign limit = 17'(CRYSTAL_HZ / rtc_pkg::EIGHTS_PER_S - 1);
    // hundredths by fractional accumulation: step 100 per crystal cycle
    assign hacc_d = hacc_q + 17'(rtc_pkg::HUNDREDTHS_PER_S);
    assign hwrap = hacc_d >= 17'(CRYSTAL_HZ);
    assign acc_d = acc_q + 17'h00001;

    // crystal count, compensation applied at the last 1/128 of each second
    always_ff @(posedge clk_i)
    begin
        tick_128_o <= 1'b0;
        tick_100_o <= 1'b0;
        if (por_i)
        begin
            acc_q <= 17'h00000;
            hacc_q <= 17'h00000;
            eighth_q <= 7'h00;
        end
        else if (xtal_tick_i)
        begin
            if ($signed({1'b0, acc_q}) >= $signed({1'b0, limit}) - ((eighth_q == 7'h7F) ? 18'($signed(trim)) : 18'sh0))
            begin
                acc_q <= 17'h00000;
                eighth_q <= eighth_q + 7'h01;
                tick_128_o <= 1'b1;
            end
            else
            begin
                acc_q <= acc_d;
            end
            hacc_q <= hwrap ? hacc_d - 17'(CRYSTAL_HZ) : hacc_d;
            tick_100_o <= hwrap;
        end
    end
endmodule : rtc_tick_gen
`default_nettype wire

// [rtc_timekeeping_core.sv]
// real-time clock core: time counters, configuration, key protection,
// compensation registers and interval alarm on the special-function bus.
// assumes single-cycle byte reads and writes from the core, a crystal
// edge pulse, and a power-on reset separate from the system reset.
//
// Notes on behaviour
// - counting paced by crystal tick only
// - runs in every power saving mode
// - counters cleared by power-on reset only
// - timekeeping writes need key 0xEA first
// - whole-byte register access only
// - nominal and temperature compensation registers
// - midnight flag sticky until software clears
// - deep sleep refused while midnight flagged
// - hour wrap bit picks 24 or 256
// - hour wrap bit kept across system reset, cleared by power-on reset
// - bits 5:4 select interval tick
// - alarm periodic or single interval
// - enable clear stops and clears counter
// - alarm flag set only by hardware
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeping_core (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic por_i,
    input wire logic xtal_tick_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    output logic [7:0] interrupt_pin_config_o,
    output logic midnight_o,
    output logic alarm_o,
    output logic deep_sleep_allow_o
);
    // configuration fields
    logic midnight_q;
    logic hour_wrap_select_q;
    logic [1:0] interval_tick_select_q;
    logic single_interval_select_q;
    logic alarm_q;
    logic interval_timer_enable_q;

    // counters and plain registers
    logic [7:0] hundredths_q;
    logic [7:0] seconds_q;
    logic [7:0] minutes_q;
    logic [7:0] hours_q;
    logic [7:0] interval_q;
    logic [7:0] unlock_key_q;
    logic [7:0] nominal_comp_q;
    logic [7:0] temp_comp_q;
    logic [7:0] int_pin_cfg_q;
    logic [7:0] rdata_d;

    // timebase and carries
    logic tick_100;
    logic tick_128;
    logic hs_wrap;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic [7:0] hours_last;
    logic elapsed;

    // register decode
    logic wr_cfg;
    logic wr_hs;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_ival;
    logic wr_key;
    logic wr_ncomp;
    logic wr_tcomp;
    logic wr_ipc;
    logic unlocked;
    logic cfg_clr_mid;
    logic cfg_clr_alarm;

    rtc_tick_gen u_tick (
        .clk_i(clk_i),
        .por_i(por_i),
        .xtal_tick_i(xtal_tick_i),
        .nominal_comp_i(nominal_comp_q),
        .temp_comp_i(temp_comp_q),
        .tick_100_o(tick_100),
        .tick_128_o(tick_128)
    );

    assign wr_cfg = sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_CONFIG;
    assign wr_ival = sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_INTERVAL;
    assign wr_key = sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_UNLOCK_KEY;
    assign wr_ncomp = sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_NOMINAL_COMP;
    assign wr_tcomp = sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_TEMP_COMP;
    assign unlocked = unlock_key_q == rtc_pkg::TIMEKEEP_KEY;
    assign wr_hs = unlocked && sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_HUNDREDTHS;
    assign wr_sec = unlocked && sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_SECONDS;
    assign wr_min = unlocked && sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_MINUTES;
    assign wr_hour = unlocked && sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_HOURS;
    assign wr_ipc = unlocked && sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_INT_PIN_CFG;
    // software may only clear flags by writing zero
    assign cfg_clr_mid = wr_cfg && !sfr_wdata_i[rtc_pkg::CFG_MIDNIGHT_BIT];
    assign cfg_clr_alarm = wr_cfg && !sfr_wdata_i[rtc_pkg::CFG_ALARM_BIT];

    assign hs_wrap = tick_100 && hundredths_q == rtc_pkg::HUNDREDTHS_LAST;
    assign sec_wrap = hs_wrap && seconds_q == rtc_pkg::SIXTY_LAST;
    assign min_wrap = sec_wrap && minutes_q == rtc_pkg::SIXTY_LAST;
    assign hours_last = hour_wrap_select_q ? rtc_pkg::HOURS_LAST_24 : rtc_pkg::HOURS_LAST_256;
    assign hour_wrap = min_wrap && hours_q == hours_last;

    // no sleep or system reset gating
    always_ff @(posedge clk_i)
    begin
        if (por_i)
        begin
            hundredths_q <= rtc_pkg::REG_RESET;
            seconds_q <= rtc_pkg::REG_RESET;
            minutes_q <= rtc_pkg::REG_RESET;
            hours_q <= rtc_pkg::REG_RESET;
        end
        else
        begin
            if (wr_hs)
                hundredths_q <= sfr_wdata_i;
            else if (tick_100)
                hundredths_q <= hs_wrap ? 8'h00 : hundredths_q + 8'h01;
            if (wr_sec)
                seconds_q <= sfr_wdata_i;
            else if (hs_wrap)
                seconds_q <= sec_wrap ? 8'h00 : seconds_q + 8'h01;
            if (wr_min)
                minutes_q <= sfr_wdata_i;
            else if (sec_wrap)
                minutes_q <= min_wrap ? 8'h00 : minutes_q + 8'h01;
            if (wr_hour)
                hours_q <= sfr_wdata_i;
            else if (min_wrap)
                hours_q <= hour_wrap ? 8'h00 : hours_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (por_i)
            hour_wrap_select_q <= rtc_pkg::CONFIG_RESET[rtc_pkg::CFG_HOUR_WRAP_BIT];
        else if (wr_cfg)
            hour_wrap_select_q <= sfr_wdata_i[rtc_pkg::CFG_HOUR_WRAP_BIT];
    end

    // midnight and alarm flags, set wins over clear
    always_ff @(posedge clk_i)
    begin
        if (por_i || sys_rst_i)
        begin
            midnight_q <= rtc_pkg::CONFIG_RESET[rtc_pkg::CFG_MIDNIGHT_BIT];
            alarm_q <= rtc_pkg::CONFIG_RESET[rtc_pkg::CFG_ALARM_BIT];
        end
        else
        begin
            if (hour_wrap)
                midnight_q <= 1'b1;
            else if (cfg_clr_mid)
                midnight_q <= 1'b0;
            if (elapsed)
                alarm_q <= 1'b1;
            else if (cfg_clr_alarm)
                alarm_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (por_i || sys_rst_i)
        begin
            interval_tick_select_q <= rtc_pkg::CONFIG_RESET[rtc_pkg::CFG_TICK_SEL_HI:rtc_pkg::CFG_TICK_SEL_LO];
            single_interval_select_q <= rtc_pkg::CONFIG_RESET[rtc_pkg::CFG_SINGLE_BIT];
            interval_timer_enable_q <= rtc_pkg::CONFIG_RESET[rtc_pkg::CFG_ENABLE_BIT];
        end
        else if (wr_cfg)
        begin
            interval_tick_select_q <= sfr_wdata_i[rtc_pkg::CFG_TICK_SEL_HI:rtc_pkg::CFG_TICK_SEL_LO];
            single_interval_select_q <= sfr_wdata_i[rtc_pkg::CFG_SINGLE_BIT];
            interval_timer_enable_q <= sfr_wdata_i[rtc_pkg::CFG_ENABLE_BIT];
        end
    end

    // plain registers: key, interval, compensation, pin config
    always_ff @(posedge clk_i)
    begin
        if (por_i || sys_rst_i)
        begin
            unlock_key_q <= rtc_pkg::REG_RESET;
            interval_q <= rtc_pkg::REG_RESET;
            nominal_comp_q <= rtc_pkg::REG_RESET;
            temp_comp_q <= rtc_pkg::REG_RESET;
            int_pin_cfg_q <= rtc_pkg::REG_RESET;
        end
        else
        begin
            if (wr_key)
                unlock_key_q <= sfr_wdata_i;
            if (wr_ival)
                interval_q <= sfr_wdata_i;
            if (wr_ncomp)
                nominal_comp_q <= sfr_wdata_i;
            if (wr_tcomp)
                temp_comp_q <= sfr_wdata_i;
            if (wr_ipc)
                int_pin_cfg_q <= sfr_wdata_i;
        end
    end

    rtc_interval u_interval (
        .clk_i(clk_i),
        .por_i(por_i || sys_rst_i),
        .enable_i(interval_timer_enable_q),
        .single_i(single_interval_select_q),
        .tick_sel_i(interval_tick_select_q),
        .target_i(interval_q),
        .tick_128_i(tick_128),
        .tick_sec_i(hs_wrap),
        .tick_min_i(sec_wrap),
        .tick_hour_i(min_wrap),
        .elapsed_o(elapsed)
    );

    // read mux, unmapped reads give zero
    always_comb
    begin
        rdata_d = 8'h00;
        case (sfr_addr_i)
            rtc_pkg::ADDR_CONFIG: rdata_d = {midnight_q, hour_wrap_select_q, interval_tick_select_q,
                                             single_interval_select_q, alarm_q, interval_timer_enable_q,
                                             rtc_pkg::CONFIG_RESET[rtc_pkg::CFG_RESERVED_BIT]};
            rtc_pkg::ADDR_HUNDREDTHS: rdata_d = hundredths_q;
            rtc_pkg::ADDR_SECONDS: rdata_d = seconds_q;
            rtc_pkg::ADDR_MINUTES: rdata_d = minutes_q;
            rtc_pkg::ADDR_HOURS: rdata_d = hours_q;
            rtc_pkg::ADDR_INTERVAL: rdata_d = interval_q;
            rtc_pkg::ADDR_UNLOCK_KEY: rdata_d = unlock_key_q;
            rtc_pkg::ADDR_NOMINAL_COMP: rdata_d = nominal_comp_q;
            rtc_pkg::ADDR_TEMP_COMP: rdata_d = temp_comp_q;
            rtc_pkg::ADDR_INT_PIN_CFG: rdata_d = int_pin_cfg_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // registered read data, one cycle after the read strobe
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || por_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i)
            sfr_rdata_o <= rdata_d;
    end

    assign sfr_hit_o = (sfr_rd_i || sfr_wr_i) && (rdata_d != 8'h00 || sfr_addr_i == rtc_pkg::ADDR_CONFIG ||
                       sfr_addr_i[7:4] == 4'hA || sfr_addr_i == rtc_pkg::ADDR_UNLOCK_KEY ||
                       sfr_addr_i[7:1] == 7'h7B || sfr_addr_i == rtc_pkg::ADDR_INT_PIN_CFG);
    assign interrupt_pin_config_o = int_pin_cfg_q;
    assign midnight_o = midnight_q;
    assign alarm_o = alarm_q;
    assign deep_sleep_allow_o = !midnight_q;
endmodule : rtc_timekeeping_core
`default_nettype wire

// [rtc_timekeeping_core_bench.sv]
// self-checking bench for the real-time clock core.
// assumes rtc_pkg, the core, the crystal model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeping_core_bench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic por_i = 1'b1;
    logic xtal_tick;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] pin_cfg;
    logic hit, midnight, alarm, sleep_ok, got;
    int fail_count = 0;
    int samples_checked = 0;
    // system clock
    always #5 clk_i = ~clk_i;
    rtc_crystal_model u_xtal (.clk_i(clk_i), .tick_o(xtal_tick));
    rtc_timekeeping_core u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .xtal_tick_i(xtal_tick),
        .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
        .sfr_hit_o(hit), .interrupt_pin_config_o(pin_cfg), .midnight_o(midnight), .alarm_o(alarm),
        .deep_sleep_allow_o(sleep_ok));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        #1;
    endtask : sfr_write
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(posedge clk_i);
        #1;
        check(what, rdata, exp);
    endtask : rd_chk
    task automatic wait_flag(input bit want_alarm, input int limit);
        got = 1'b0;
        for (int n = 0; n < limit && !got; n++)
        begin
            @(posedge clk_i);
            #1;
            got = ((want_alarm ? alarm : midnight) === 1'b1);
        end
    endtask : wait_flag
    task automatic set_time(input logic [7:0] h, input logic [7:0] m, input logic [7:0] s, input logic [7:0] c);
        sfr_write(8'hC1, rtc_pkg::TIMEKEEP_KEY);
        sfr_write(8'hA5, h);
        sfr_write(8'hA4, m);
        sfr_write(8'hA3, s);
        sfr_write(8'hA2, c);
        sfr_write(8'hC1, 8'h00);
    endtask : set_time
    task automatic pulse_reset(input bit power);
        @(posedge clk_i);
        por_i <= power;
        sys_rst_i <= ~power;
        @(posedge clk_i);
        por_i <= 1'b0;
        sys_rst_i <= 1'b0;
    endtask : pulse_reset
    task automatic test_reset_values();
        rd_chk("config", 8'hA1, rtc_pkg::CONFIG_RESET);
        rd_chk("hours", 8'hA5, 8'h00);
        rd_chk("unmapped", 8'hB0, 8'h00);
        // address hit is looked at while the read strobe stands
        @(posedge clk_i);
        addr <= 8'hF7;
        rd <= 1'b1;
        #1;
        check("hit mapped", {7'h00, hit}, 8'h01);
        @(posedge clk_i);
        addr <= 8'hB0;
        #1;
        check("hit", {7'h00, hit}, 8'h00);
        @(posedge clk_i);
        rd <= 1'b0;
    endtask : test_reset_values
    task automatic test_key();
        sfr_write(8'hA5, 8'h05);
        rd_chk("locked hours", 8'hA5, 8'h00);
        sfr_write(8'hC1, rtc_pkg::TIMEKEEP_KEY);
        sfr_write(8'hA5, 8'h05);
        sfr_write(8'hFF, 8'h80);
        sfr_write(8'hC1, 8'h00);
        sfr_write(8'hFF, 8'h11);
        sfr_write(8'hA5, 8'h09);
        rd_chk("hours", 8'hA5, 8'h05);
        check("pin config", pin_cfg, 8'h80);
    endtask : test_key
    task automatic test_rw_regs();
        logic [7:0] regs [3] = '{8'hA6, 8'hF6, 8'hF7};
        foreach (regs[i])
        begin
            sfr_write(regs[i], 8'h5A);
            rd_chk("rw register", regs[i], 8'h5A);
            sfr_write(regs[i], 8'h00);
        end
    endtask : test_rw_regs
    task automatic test_resets();
        sfr_write(8'hA1, 8'h41);
        pulse_reset(1'b0);
        rd_chk("hours warm", 8'hA5, 8'h05);
        rd_chk("config warm", 8'hA1, 8'h41);
        pulse_reset(1'b1);
        rd_chk("hours cold", 8'hA5, 8'h00);
        rd_chk("config cold", 8'hA1, 8'h01);
    endtask : test_resets
    task automatic test_rollover();
        for (int m = 0; m < 2; m++)
        begin
            sfr_write(8'hA1, m ? 8'h41 : 8'h01);
            set_time(8'h17, 8'h3B, 8'h3B, 8'h63);
            wait_flag(1'b0, 1500);
            check("midnight", {7'h00, got}, {7'h00, m[0]});
            check("sleep allow", {7'h00, sleep_ok}, {7'h00, ~m[0]});
            rd_chk("hours wrap", 8'hA5, m ? 8'h00 : 8'h18);
            rd_chk("minutes wrap", 8'hA4, 8'h00);
            rd_chk("seconds wrap", 8'hA3, 8'h00);
            sfr_write(8'hA1, m ? 8'h41 : 8'h01);
            check("midnight cleared", {7'h00, midnight}, 8'h00);
        end
    endtask : test_rollover
    task automatic test_interval();
        sfr_write(8'hA6, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            sfr_write(8'hA1, {2'b00, c[1:0], 4'h3});
            set_time(8'h00, 8'h3B, 8'h3B, 8'h63);
            wait_flag(1'b1, 1500);
            check("alarm per base", {7'h00, got}, 8'h01);
            sfr_write(8'hA1, 8'h01);
        end
        sfr_write(8'hA6, 8'h02);
        sfr_write(8'hA1, 8'h07);
        check("alarm by write", {7'h00, alarm}, 8'h00);
        wait_flag(1'b1, 1200);
        check("alarm first", {7'h00, got}, 8'h01);
        sfr_write(8'hA1, 8'h03);
        check("alarm cleared", {7'h00, alarm}, 8'h00);
        wait_flag(1'b1, 1200);
        check("alarm again", {7'h00, got}, 8'h01);
        sfr_write(8'hA1, 8'h01);
        wait_flag(1'b1, 1200);
        check("alarm disabled", {7'h00, got}, 8'h00);
        sfr_write(8'hA1, 8'h0B);
        wait_flag(1'b1, 1200);
        check("alarm single", {7'h00, got}, 8'h01);
        sfr_write(8'hA1, 8'h0B);
        wait_flag(1'b1, 1200);
        check("alarm once only", {7'h00, got}, 8'h00);
    endtask : test_interval
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // main sequence after both resets are held for ten cycles
    initial
    begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        por_i <= 1'b0;
        test_reset_values();
        test_key();
        test_rw_regs();
        test_resets();
        test_rollover();
        test_interval();
        wrap_up();
    end
    // watchdog against a hung scenario
    initial
    begin
        #900000;
        fail_count++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : rtc_timekeeping_core_bench
bind rtc_timekeeping_core rtc_timekeeping_core_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i),
    .xtal_tick_i(xtal_tick_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
    .interrupt_pin_config_o(interrupt_pin_config_o), .midnight_o(midnight_o), .alarm_o(alarm_o),
    .deep_sleep_allow_o(deep_sleep_allow_o));
`default_nettype wire

// [rtc_timekeeping_core_chk.sv]
// port checker for the real-time clock core.
// assumes it is bound to the core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeping_core_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic por_i,
    input wire logic xtal_tick_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sfr_hit_o,
    input wire logic [7:0] interrupt_pin_config_o,
    input wire logic midnight_o,
    input wire logic alarm_o,
    input wire logic deep_sleep_allow_o
);
    logic [7:0] key_q;
    // shadow of the unlock key as software last wrote it
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || por_i)
            key_q <= 8'h00;
        else if (sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_UNLOCK_KEY)
            key_q <= sfr_wdata_i;
    end
    // decoded write strobes and expected address hit
    wire cfg_wr = sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_CONFIG;
    wire pin_wr = sfr_wr_i && sfr_addr_i == rtc_pkg::ADDR_INT_PIN_CFG;
    // hit is only claimed while a read or write strobe is up
    wire hit_exp = (sfr_rd_i || sfr_wr_i) && (sfr_addr_i[7:4] == 4'hA || sfr_addr_i == 8'hC1 ||
        sfr_addr_i == 8'hF6 || sfr_addr_i == 8'hF7 || sfr_addr_i == 8'hFF);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i || por_i);
    a_sleep_follows_flag: assert property (deep_sleep_allow_o != midnight_o)
        else $error("deep sleep permission disagrees with midnight flag");
    a_unmapped_zero: assert property (sfr_rd_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read returned nonzero");
    a_rdata_holds: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data changed without a read");
    a_key_blocks_pin: assert property (pin_wr && key_q != 8'hEA |=> $stable(interrupt_pin_config_o))
        else $error("pin config written while locked");
    a_key_opens_pin: assert property (pin_wr && key_q == 8'hEA |=> interrupt_pin_config_o == $past(sfr_wdata_i))
        else $error("pin config not written while unlocked");
    a_midnight_sticky: assert property (midnight_o && !(cfg_wr && !sfr_wdata_i[7]) |=> midnight_o)
        else $error("midnight flag dropped without clear");
    a_alarm_sticky: assert property (alarm_o && !(cfg_wr && !sfr_wdata_i[2]) |=> alarm_o)
        else $error("alarm flag dropped without clear");
    a_hit_decode: assert property (sfr_hit_o == hit_exp)
        else $error("address hit decode wrong");
    a_warm_reset_flags: assert property (disable iff (por_i) sys_rst_i |=> !midnight_o && !alarm_o)
        else $error("flags survive warm reset");
    a_por_clears: assert property (disable iff (sys_rst_i) por_i |=> !midnight_o && interrupt_pin_config_o == 8'h00)
        else $error("power-on reset left state");
endmodule : rtc_timekeeping_core_chk
`default_nettype wire
